// [logic/serial_status_defines.svh]
`ifndef SERIAL_STATUS_DEFINES_SVH
`define SERIAL_STATUS_DEFINES_SVH

// Register byte addresses
`define SER_STATUS_ADDR 16'hff84
`define SER_CTRL_ADDR 16'hff88
`define SER_TXDATA_ADDR 16'hff8c
`define SER_RXDATA_ADDR 16'hff90
`define SER_IRQSTAT_ADDR 16'hff94
`define SER_IRQMASK_ADDR 16'hff98

// Status register field positions
`define ST_TX_REG_EMPTY_FLAG 7
`define ST_RX_REG_FULL_FLAG 6
`define ST_OVERRUN_ERR_FLAG 5
`define ST_FER 4
`define ST_PER 3
`define ST_TX_END_FLAG 2
`define ST_MPB 1
`define ST_TX_MULTIPROC_BIT 0
`define STATUS_RESET 8'h84
`define TX_REG_EMPTY_FLAG_RESET 1'b1
`define TX_END_FLAG_RESET 1'b1

// Control register field positions
`define CT_RE 0
`define CT_TE 1
`define CT_PAREN 2
`define CT_ODD 3
`define CT_MPFMT 4
`define CT_TIE 5
`define CTRL_RESET 8'h00

// Interrupt status and mask fields
`define IRQ_TXEMPTY 0
`define IRQ_TXEND 1
`define IRQ_RXFULL 2
`define IRQ_RXERR 3

// Bit timing
`define CLK_HZ 20000000
`define BAUD_HZ 1000000
`define BIT_CYCLES (`CLK_HZ / `BAUD_HZ)

`endif

// [logic/serial_pkg.sv]
package serial_pkg;

   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} txState_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rxState_e;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] txData;
      logic [7:0] rxData;
      logic tx_reg_empty_flag;
      logic rx_reg_full_flag;
      logic overrun_err_flag;
      logic framing_err_flag;
      logic parity_err_flag;
      logic tx_end_flag;
      logic rx_multiproc_bit;
      logic tx_multiproc_bit;
      logic [4:0] rdOne;
      logic [3:0] irqStat;
      logic [3:0] irqMask;
      txState_e txState;
      logic [10:0] txShift;
      logic [3:0] txCnt;
      rxState_e rxState;
      logic [10:0] rxShift;
      logic [3:0] rxCnt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic txd;
      logic irq;
      logic txEmptyIrq;
   } state_s;

endpackage

// [logic/bit_rate_divider.sv]
`timescale 1ns/1ps
`include "serial_status_defines.svh"

module bit_rate_divider
#(
   parameter int DIV = `BIT_CYCLES
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic restart,
   input wire logic halfStart,
   output logic tick
);
   localparam logic [15:0] LAST = 16'(DIV - 1);
   localparam logic [15:0] HALF = 16'(DIV - 1 - DIV / 2);

   logic [15:0] cnt_ff;

   // A half preset lets the receiver sample each bit near its centre
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_ff <= 16'h0000;
         tick <= 1'b0;
      end
      else if (restart)
      begin
         cnt_ff <= halfStart ? HALF : 16'h0000;
         tick <= 1'b0;
      end
      else if (cnt_ff >= LAST)
      begin
         cnt_ff <= 16'h0000;
         tick <= 1'b1;
      end
      else
      begin
         cnt_ff <= cnt_ff + 16'h0001;
         tick <= 1'b0;
      end
   end

endmodule

// [logic/serial_status_flags.sv]
`timescale 1ns/1ps
`include "serial_status_defines.svh"

module serial_status_flags
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic txd,
   output logic txEmptyIrq,
   output logic irq
);
   localparam serial_pkg::state_s RST_STATE = '{
      ctrl: `CTRL_RESET,
      tx_reg_empty_flag: `TX_REG_EMPTY_FLAG_RESET,
      tx_end_flag: `TX_END_FLAG_RESET,
      txState: serial_pkg::TX_IDLE,
      rxState: serial_pkg::RX_IDLE,
      txd: 1'b1,
      default: '0
   };

   serial_pkg::state_s st_ff;
   serial_pkg::state_s nxt_st;

   logic txTick;
   logic rxTick;
   logic txRestart;
   logic rxRestart;
   logic setupCycle;
   logic accessDone;
   logic [7:0] statusByte;
   logic [3:0] frameLen;
   logic [3:0] txLen;
   logic [10:0] rxBits;
   logic [7:0] rxByte;
   logic rxParBit;
   logic rxMpBit;
   logic rxStopBit;
   logic parityBad;
   logic [3:0] idx;
   logic [3:0] events;

   bit_rate_divider #(.DIV(`BIT_CYCLES)) txDiv
   (
      .clk(clk),
      .nrst(nrst),
      .restart(txRestart),
      .halfStart(1'b0),
      .tick(txTick)
   );

   bit_rate_divider #(.DIV(`BIT_CYCLES)) rxDiv
   (
      .clk(clk),
      .nrst(nrst),
      .restart(rxRestart),
      .halfStart(1'b1),
      .tick(rxTick)
   );

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign txd = st_ff.txd;
   assign irq = st_ff.irq;
   assign txEmptyIrq = st_ff.txEmptyIrq;

   always_comb
   begin
      nxt_st = st_ff;
      txRestart = 1'b0;
      rxRestart = 1'b0;
      events = 4'h0;
      idx = 4'h0;
      rxBits = st_ff.rxShift;
      rxByte = 8'h00;
      rxParBit = 1'b0;
      rxMpBit = 1'b0;
      rxStopBit = 1'b1;
      parityBad = 1'b0;

      statusByte = {st_ff.tx_reg_empty_flag, st_ff.rx_reg_full_flag, st_ff.overrun_err_flag, st_ff.framing_err_flag, st_ff.parity_err_flag,
         st_ff.tx_end_flag, st_ff.rx_multiproc_bit, st_ff.tx_multiproc_bit};
      // Data bits, optional parity, optional multiprocessor bit, one stop bit
      frameLen = 4'd9 + {3'b000, st_ff.ctrl[`CT_PAREN]} + {3'b000, st_ff.ctrl[`CT_MPFMT]};
      txLen = frameLen + 4'd1;
      setupCycle = psel && !penable;
      accessDone = psel && penable && st_ff.pready;

      // Zero wait states: the answer is ready in the first access cycle
      nxt_st.pready = setupCycle;
      if (setupCycle)
      begin
         nxt_st.pslverr = 1'b0;
         unique case (paddr)
            `SER_STATUS_ADDR: nxt_st.prdata = {24'h00_0000, statusByte};
            `SER_CTRL_ADDR: nxt_st.prdata = {24'h00_0000, st_ff.ctrl};
            `SER_TXDATA_ADDR: nxt_st.prdata = {24'h00_0000, st_ff.txData};
            `SER_RXDATA_ADDR: nxt_st.prdata = {24'h00_0000, st_ff.rxData};
            `SER_IRQSTAT_ADDR: nxt_st.prdata = {28'h000_0000, st_ff.irqStat};
            `SER_IRQMASK_ADDR: nxt_st.prdata = {28'h000_0000, st_ff.irqMask};
            default:
            begin
               nxt_st.prdata = 32'h0000_0000;
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end
      else if (accessDone)
      begin
         nxt_st.pslverr = 1'b0;
      end

      // Software clears are applied first so a hardware set later in the cycle wins
      if (accessDone && !pwrite && paddr == `SER_STATUS_ADDR)
      begin
         nxt_st.rdOne = st_ff.rdOne | statusByte[7:3];
      end
      if (accessDone && pwrite)
      begin
         unique case (paddr)
            `SER_STATUS_ADDR:
            begin
               if (!pwdata[`ST_TX_REG_EMPTY_FLAG] && st_ff.rdOne[4])
               begin
                  nxt_st.tx_reg_empty_flag = 1'b0;
                  nxt_st.tx_end_flag = 1'b0;
                  nxt_st.rdOne[4] = 1'b0;
               end
               if (!pwdata[`ST_RX_REG_FULL_FLAG] && st_ff.rdOne[3])
               begin
                  nxt_st.rx_reg_full_flag = 1'b0;
                  nxt_st.rdOne[3] = 1'b0;
               end
               if (!pwdata[`ST_OVERRUN_ERR_FLAG] && st_ff.rdOne[2])
               begin
                  nxt_st.overrun_err_flag = 1'b0;
                  nxt_st.rdOne[2] = 1'b0;
               end
               if (!pwdata[`ST_FER] && st_ff.rdOne[1])
               begin
                  nxt_st.framing_err_flag = 1'b0;
                  nxt_st.rdOne[1] = 1'b0;
               end
               if (!pwdata[`ST_PER] && st_ff.rdOne[0])
               begin
                  nxt_st.parity_err_flag = 1'b0;
                  nxt_st.rdOne[0] = 1'b0;
               end
               nxt_st.tx_multiproc_bit = pwdata[`ST_TX_MULTIPROC_BIT];
            end
            `SER_CTRL_ADDR: nxt_st.ctrl = pwdata[7:0];
            `SER_TXDATA_ADDR:
            begin
               // The transfer controller writes here on a tx-empty request
               nxt_st.txData = pwdata[7:0];
               nxt_st.tx_reg_empty_flag = 1'b0;
               nxt_st.tx_end_flag = 1'b0;
            end
            `SER_RXDATA_ADDR:
            begin
            end
            `SER_IRQSTAT_ADDR: nxt_st.irqStat = st_ff.irqStat & ~pwdata[3:0];
            `SER_IRQMASK_ADDR: nxt_st.irqMask = pwdata[3:0];
            default:
            begin
            end
         endcase
      end

      // Transmitter
      unique case (st_ff.txState)
         serial_pkg::TX_IDLE:
         begin
            nxt_st.txd = 1'b1;
            if (st_ff.ctrl[`CT_TE] && !st_ff.tx_reg_empty_flag)
            begin
               // Start bit goes out now, the rest follows on bit ticks
               nxt_st.txd = 1'b0;
               nxt_st.txCnt = 4'd0;
               nxt_st.txShift = 11'h7ff;
               nxt_st.txShift[7:0] = st_ff.txData;
               idx = 4'd8;
               if (st_ff.ctrl[`CT_PAREN])
               begin
                  nxt_st.txShift[idx] = ^st_ff.txData ^ st_ff.ctrl[`CT_ODD];
                  idx = idx + 4'd1;
               end
               if (st_ff.ctrl[`CT_MPFMT])
               begin
                  nxt_st.txShift[idx] = st_ff.tx_multiproc_bit;
               end
               // Tx end was cleared by the write that emptied tx_reg_empty_flag, unless TE was off or a frame ended in that same cycle
               nxt_st.tx_reg_empty_flag = 1'b1;
               events[`IRQ_TXEMPTY] = 1'b1;
               txRestart = 1'b1;
               nxt_st.txState = serial_pkg::TX_SHIFT;
            end
         end
         serial_pkg::TX_SHIFT:
         begin
            if (txTick)
            begin
               if (st_ff.txCnt == txLen - 4'd1)
               begin
                  nxt_st.txd = 1'b1;
                  nxt_st.txState = serial_pkg::TX_IDLE;
                  if (st_ff.tx_reg_empty_flag)
                  begin
                     nxt_st.tx_end_flag = 1'b1;
                     events[`IRQ_TXEND] = 1'b1;
                  end
               end
               else
               begin
                  nxt_st.txd = st_ff.txShift[0];
                  nxt_st.txShift = {1'b1, st_ff.txShift[10:1]};
                  nxt_st.txCnt = st_ff.txCnt + 4'd1;
               end
            end
         end
      endcase
      if (!st_ff.ctrl[`CT_TE])
      begin
         // Disabling the transmitter aborts a character in flight
         nxt_st.txState = serial_pkg::TX_IDLE;
         nxt_st.txd = 1'b1;
         nxt_st.tx_end_flag = 1'b1;
      end

      // Receiver
      unique case (st_ff.rxState)
         serial_pkg::RX_IDLE:
         begin
            if (st_ff.ctrl[`CT_RE] && !st_ff.parity_err_flag && !st_ff.framing_err_flag && !st_ff.overrun_err_flag && !rxd)
            begin
               rxRestart = 1'b1;
               nxt_st.rxState = serial_pkg::RX_START;
            end
         end
         serial_pkg::RX_START:
         begin
            if (rxTick)
            begin
               // A start bit gone high by mid-bit is a glitch, not a frame
               nxt_st.rxState = rxd ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
               nxt_st.rxCnt = 4'd0;
            end
         end
         serial_pkg::RX_DATA:
         begin
            if (rxTick)
            begin
               rxBits[st_ff.rxCnt] = rxd;
               nxt_st.rxShift = rxBits;
               nxt_st.rxCnt = st_ff.rxCnt + 4'd1;
               if (st_ff.rxCnt == frameLen - 4'd1)
               begin
                  nxt_st.rxState = serial_pkg::RX_IDLE;
                  rxByte = rxBits[7:0];
                  idx = 4'd8;
                  if (st_ff.ctrl[`CT_PAREN])
                  begin
                     rxParBit = rxBits[idx];
                     parityBad = (^{rxByte, rxParBit}) != st_ff.ctrl[`CT_ODD];
                     idx = idx + 4'd1;
                  end
                  if (st_ff.ctrl[`CT_MPFMT])
                  begin
                     rxMpBit = rxBits[idx];
                     idx = idx + 4'd1;
                  end
                  rxStopBit = rxBits[idx];
                  if (st_ff.rx_reg_full_flag)
                  begin
                     nxt_st.overrun_err_flag = 1'b1;
                     events[`IRQ_RXERR] = 1'b1;
                  end
                  else
                  begin
                     nxt_st.rxData = rxByte;
                     if (st_ff.ctrl[`CT_MPFMT])
                     begin
                        nxt_st.rx_multiproc_bit = rxMpBit;
                     end
                     if (!rxStopBit)
                     begin
                        nxt_st.framing_err_flag = 1'b1;
                        events[`IRQ_RXERR] = 1'b1;
                     end
                     else if (parityBad)
                     begin
                        nxt_st.parity_err_flag = 1'b1;
                        events[`IRQ_RXERR] = 1'b1;
                     end
                     else
                     begin
                        nxt_st.rx_reg_full_flag = 1'b1;
                        events[`IRQ_RXFULL] = 1'b1;
                     end
                  end
               end
            end
         end
      endcase
      if (!st_ff.ctrl[`CT_RE])
      begin
         // Dropping receive enable abandons the frame; parity error cannot set and mp bit is held, other receive flags can still set this cycle
         nxt_st.rxState = serial_pkg::RX_IDLE;
         nxt_st.rx_multiproc_bit = st_ff.rx_multiproc_bit;
         nxt_st.parity_err_flag = nxt_st.parity_err_flag & st_ff.parity_err_flag;
      end

      // Sticky interrupt status, set wins over the write-one clear
      nxt_st.irqStat = nxt_st.irqStat | events;
      nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqMask);
      nxt_st.txEmptyIrq = nxt_st.tx_reg_empty_flag && nxt_st.ctrl[`CT_TIE];
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_ff <= RST_STATE;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

endmodule

// [test/serial_status_checker.sv]
`timescale 1ns/1ps
`include "serial_status_defines.svh"
module serial_status_checker
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rxd,
   input wire logic txd,
   input wire logic txEmptyIrq,
   input wire logic irq
);
   logic [7:0] ctrl_ff;
   logic [3:0] mask_ff;
   logic [4:0] run_ff;
   logic wrDone;
   logic mapped;
   assign wrDone = psel && penable && pready && pwrite;
   assign mapped = paddr inside {`SER_STATUS_ADDR, `SER_CTRL_ADDR, `SER_TXDATA_ADDR,
      `SER_RXDATA_ADDR, `SER_IRQSTAT_ADDR, `SER_IRQMASK_ADDR};
   // Run starts saturated so the first frame after reset is not judged short
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_ff <= 8'h00;
         mask_ff <= 4'h0;
         run_ff <= 5'h1f;
      end
      else
      begin
         if (wrDone && paddr == `SER_CTRL_ADDR)
            ctrl_ff <= pwdata[7:0];
         if (wrDone && paddr == `SER_IRQMASK_ADDR)
            mask_ff <= pwdata[3:0];
         if ($changed(txd))
            run_ff <= 5'h00;
         else if (run_ff != 5'h1f)
            run_ff <= run_ff + 5'h01;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence setupS;
      psel && !penable;
   endsequence
   sequence accessS;
      psel && penable && pready;
   endsequence
   AST_APB_ANSWER: assert property (setupS |=> accessS)
      else $error("no ready after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_UNMAPPED_ERR: assert property (accessS and !mapped |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   AST_MAPPED_OK: assert property (accessS and mapped |-> !pslverr && prdata[31:8] == 24'h00_0000)
      else $error("mapped access answered wrongly");
   AST_TX_END_FLAG_TE_OFF: assert property (accessS and !pwrite && paddr == `SER_STATUS_ADDR
      && !ctrl_ff[1] && !$past(ctrl_ff[1], 3) |-> prdata[2])
      else $error("tx end low while transmit disabled");
   AST_BIT_TIME: assert property ($changed(txd) |-> run_ff >= 5'd19)
      else $error("serial bit too short");
   AST_IRQ_MASKED: assert property (mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> !irq)
      else $error("interrupt with all sources masked");
   AST_TXIRQ_TIE: assert property (!ctrl_ff[5] && !$past(ctrl_ff[5]) |-> !txEmptyIrq)
      else $error("tx empty request while disabled");
   AST_TXD_RESET: assert property ($rose(nrst) |-> txd)
      else $error("line not idle after reset");
endmodule
bind serial_status_flags serial_status_checker chk (.clk, .nrst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .txEmptyIrq, .irq);

// [test/remote_station.sv]
`timescale 1ns/1ps
module remote_station
(
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   logic [9:0] got;
   logic [7:0] rxByte;
   logic rxMp;
   int rxCount = 0;
   // Line idles high between frames, as a pulled-up line would
   initial rxd = 1'b1;
   task automatic send(input logic [7:0] d, input logic parEn, input logic par, input logic mpEn,
      input logic mp);
      logic q[$];
      q = {1'b0};
      for (int i = 0; i < 8; i++)
         q.push_back(d[i]);
      if (parEn)
         q.push_back(par);
      if (mpEn)
         q.push_back(mp);
      q.push_back(1'b1);
      foreach (q[i])
      begin
         rxd <= q[i];
         repeat (20) @(posedge clk);
      end
   endtask
   // Listens in multiprocessor format only: 8 data, mp bit, stop
   always
   begin
      @(negedge txd);
      repeat (10) @(posedge clk);
      for (int i = 0; i < 10; i++)
      begin
         repeat (20) @(posedge clk);
         got[i] = txd;
      end
      rxByte = got[7:0];
      rxMp = got[8];
      rxCount++;
   end
endmodule

// [test/serial_status_flags_tb.sv]
`timescale 1ns/1ps
`include "serial_status_defines.svh"
module serial_status_flags_tb;
   logic clk, nrst, psel, penable, pwrite, rxd, txd, pready, pslverr, txEmptyIrq, irq;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] seed = 16'h3edd;
   logic [7:0] d, d2;
   logic p;
   logic err;
   int error_cnt = 0;
   int n_checks = 0;
   serial_status_flags dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rxd, .txd, .txEmptyIrq, .irq);
   remote_station station (.clk, .txd, .rxd);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic hang;
      error_cnt++;
      $display("wrong value at %0t: wait ran out", $time);
      end_sim();
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic parOf(input logic [7:0] v, input logic odd);
      return ^v ^ odd;
   endfunction
   task automatic rnd;
      seed = lfsr(seed);
      d = seed[7:0];
   endtask
   // Ends one edge after release so the next setup never lands in the same step
   task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] v);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, v};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         hang();
      rd = prdata;
      // The error response stands only in the access cycle
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitTx(input int c);
      for (int n = 0; n < 400 && station.rxCount < c; n++)
         @(posedge clk);
      if (station.rxCount < c)
         hang();
      repeat (20) @(posedge clk);
   endtask
   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      apb(0, `SER_STATUS_ADDR, 8'h00);
      chk(rd[7:0], 8'h84);
      chk1(err, 1'b0);
      apb(0, 16'hff80, 8'h00);
      chk1(err, 1'b1);
      $display("test reset done");
      apb(1, `SER_CTRL_ADDR, 8'h12);
      for (int m = 0; m < 2; m++)
      begin
         rnd();
         apb(1, `SER_STATUS_ADDR, {7'h7f, m[0]});
         apb(1, `SER_TXDATA_ADDR, d);
         apb(0, `SER_STATUS_ADDR, 8'h00);
         chk1(rd[2], 1'b0);
         waitTx(m + 1);
         chk(station.rxByte, d);
         chk1(station.rxMp, m[0]);
         apb(0, `SER_STATUS_ADDR, 8'h00);
         chk1(rd[2], 1'b1);
      end
      apb(1, `SER_STATUS_ADDR, 8'h7f);
      apb(0, `SER_STATUS_ADDR, 8'h00);
      chk1(rd[2], 1'b0);
      waitTx(3);
      chk(station.rxByte, d);
      apb(1, `SER_CTRL_ADDR, 8'h20);
      apb(1, `SER_IRQMASK_ADDR, 8'h01);
      repeat (2) @(posedge clk);
      chk1(irq, 1'b1);
      chk1(txEmptyIrq, 1'b1);
      apb(1, `SER_IRQMASK_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      chk1(irq, 1'b0);
      apb(1, `SER_IRQSTAT_ADDR, 8'h0f);
      apb(0, `SER_IRQSTAT_ADDR, 8'h00);
      chk1(rd[0], 1'b0);
      $display("test transmit done");
      apb(1, `SER_CTRL_ADDR, 8'h11);
      for (int m = 1; m >= 0; m--)
      begin
         rnd();
         station.send(d, 1'b0, 1'b0, 1'b1, m[0]);
         apb(0, `SER_STATUS_ADDR, 8'h00);
         chk1(rd[1], m[0]);
         chk1(rd[6], 1'b1);
         apb(0, `SER_RXDATA_ADDR, 8'h00);
         chk(rd[7:0], d);
         apb(1, `SER_STATUS_ADDR, 8'hbd);
      end
      rnd();
      d2 = d;
      station.send(d, 1'b0, 1'b0, 1'b1, 1'b1);
      rnd();
      station.send(d, 1'b0, 1'b0, 1'b1, 1'b0);
      apb(0, `SER_STATUS_ADDR, 8'h00);
      chk1(rd[5], 1'b1);
      apb(0, `SER_RXDATA_ADDR, 8'h00);
      chk(rd[7:0], d2);
      apb(0, `SER_STATUS_ADDR, 8'h00);
      apb(1, `SER_STATUS_ADDR, 8'h9f);
      apb(1, `SER_CTRL_ADDR, 8'h10);
      station.send(d, 1'b0, 1'b0, 1'b1, 1'b0);
      apb(0, `SER_STATUS_ADDR, 8'h00);
      chk1(rd[1], 1'b1);
      $display("test multiprocessor receive done");
      for (int o = 0; o < 2; o++)
      begin
         apb(1, `SER_CTRL_ADDR, {4'h0, o[0], 3'b101});
         rnd();
         p = parOf(d, o[0]);
         station.send(d, 1'b1, ~p, 1'b0, 1'b0);
         d2 = d;
         apb(0, `SER_STATUS_ADDR, 8'h00);
         chk1(rd[3], 1'b1);
         chk1(rd[6], 1'b0);
         apb(0, `SER_RXDATA_ADDR, 8'h00);
         chk(rd[7:0], d2);
         apb(1, `SER_STATUS_ADDR, 8'hff);
         rnd();
         station.send(d, 1'b1, parOf(d, o[0]), 1'b0, 1'b0);
         apb(0, `SER_RXDATA_ADDR, 8'h00);
         chk(rd[7:0], d2);
         apb(1, `SER_CTRL_ADDR, {4'h0, o[0], 3'b100});
         apb(0, `SER_STATUS_ADDR, 8'h00);
         chk1(rd[3], 1'b1);
         apb(1, `SER_CTRL_ADDR, {4'h0, o[0], 3'b101});
         apb(1, `SER_STATUS_ADDR, 8'hf7);
         station.send(d, 1'b1, parOf(d, o[0]), 1'b0, 1'b0);
         apb(0, `SER_STATUS_ADDR, 8'h00);
         chk1(rd[3], 1'b0);
         chk1(rd[6], 1'b1);
         apb(0, `SER_RXDATA_ADDR, 8'h00);
         chk(rd[7:0], d);
         apb(1, `SER_STATUS_ADDR, 8'hbf);
      end
      $display("test parity done");
      end_sim();
   end
endmodule
